// ### adc_result_pkg.sv
// constants and types shared by the conversion result register block
// What this block does
// RULE1: left justified: result bits 9..2 go to high byte bits 7..0.
// RULE2: left justified: result bits 1..0 go to low byte bits 7..6, rest reserved.
// RULE3: right justified: result bits 9..8 go to high byte bits 1..0, rest reserved.
// RULE4: right justified: result bits 7..0 go to low byte bits 7..0.
// RULE5: both result bytes are read/write, unknown at power-up, kept across other resets.
// RULE6: after a channel change an acquisition time passes before a conversion starts.
// RULE7: a finished conversion loads both result bytes at once with current justification.
package adc_result_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int          ADDR_W          = 2;
    localparam int          DATA_W          = 8;
    localparam int          RESULT_W        = 10;
    localparam int          CHAN_W          = 5;
    localparam logic [1:0]  ADDR_RES_HIGH   = 2'h0;
    localparam logic [1:0]  ADDR_RES_LOW    = 2'h1;
    localparam logic [1:0]  ADDR_CONTROL    = 2'h2;
    localparam logic [1:0]  ADDR_STATUS     = 2'h3;

    // ---------------------------------------------------------------
    // control and status fields
    // ---------------------------------------------------------------
    localparam int          CTL_JUSTIFY_BIT = 0;
    localparam int          CTL_CHAN_LSB    = 1;
    localparam int          CTL_CHAN_MSB    = 5;
    localparam int          CTL_START_BIT   = 6;
    localparam int          STS_ACQ_BIT     = 0;
    localparam int          STS_PEND_BIT    = 1;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [4:0]  CHAN_RESET      = 5'h00;

    // ---------------------------------------------------------------
    // justification encoding
    // ---------------------------------------------------------------
    typedef enum logic {
        JUSTIFY_LEFT  = 1'b0,
        JUSTIFY_RIGHT = 1'b1
    } justify_t;

    // ---------------------------------------------------------------
    // acquisition timing
    // ---------------------------------------------------------------
    localparam int          CLOCK_PERIOD_PS = 4000;
    localparam int          ACQ_TIME_NS     = 4970;
    localparam int          ACQ_CYCLES      = (ACQ_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int          ACQ_CNT_W       = 11;

endpackage

// ### adc_result_regs.sv
// conversion result registers with justification and acquisition pacing
`timescale 1ns/1ps
module adc_result_regs
    import adc_result_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]   regWrData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [DATA_W-1:0]   regRdData,
    // converter core
    input  wire logic                convDone,
    input  wire logic [RESULT_W-1:0] convData,
    output logic      [CHAN_W-1:0]   channelSelect,
    output logic                     convStart
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [DATA_W-1:0]    resHigh_q;
    logic [DATA_W-1:0]    resLow_q;
    justify_t             justify_q;
    logic [CHAN_W-1:0]    channel_q;
    logic                 startPend_q;
    logic                 convStart_q;
    logic [ACQ_CNT_W-1:0] acqCnt_q;
    logic                 acqReady;
    logic [DATA_W-1:0]    rdData_q;
    logic                 ctlWrite;
    logic                 chanChange;

    result_format_if fmtBus();

    assign fmtBus.conversionResult    = convData;
    assign fmtBus.resultJustifySelect = justify_q;

    result_formatter formatter (
        .fmt (fmtBus.formatter)
    );

    assign ctlWrite   = regWrite && (regAddr == ADDR_CONTROL);
    assign chanChange = ctlWrite && (regWrData[CTL_CHAN_MSB:CTL_CHAN_LSB] != channel_q);
    assign acqReady   = (acqCnt_q == '0);

    // ---------------------------------------------------------------
    // result bytes: no reset, a finished conversion wins over a write
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (convDone) begin
            resHigh_q <= fmtBus.highByte;                                        // [RULE7]
            resLow_q  <= fmtBus.lowByte;                                         // [RULE7]
        end else if (regWrite && regAddr == ADDR_RES_HIGH) begin
            resHigh_q <= regWrData;                                              // [RULE5]
        end else if (regWrite && regAddr == ADDR_RES_LOW) begin
            resLow_q  <= regWrData;                                              // [RULE5]
        end
    end

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            justify_q <= JUSTIFY_LEFT;
            channel_q <= CHAN_RESET;
        end else if (ctlWrite) begin
            justify_q <= justify_t'(regWrData[CTL_JUSTIFY_BIT]);
            channel_q <= regWrData[CTL_CHAN_MSB:CTL_CHAN_LSB];
        end
    end

    // ---------------------------------------------------------------
    // acquisition timer restarts on every channel change
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acqCnt_q <= ACQ_CNT_W'(ACQ_CYCLES);
        end else if (chanChange) begin
            acqCnt_q <= ACQ_CNT_W'(ACQ_CYCLES);                                  // [RULE6]
        end else if (!acqReady) begin
            acqCnt_q <= acqCnt_q - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // start request waits for the acquisition time
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            startPend_q <= 1'b0;
            convStart_q <= 1'b0;
        end else begin
            convStart_q <= startPend_q && acqReady && !chanChange;               // [RULE6]
            if (ctlWrite && regWrData[CTL_START_BIT]) begin
                startPend_q <= 1'b1;
            end else if (acqReady && !chanChange) begin
                startPend_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read data, one cycle after the strobe
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdData_q <= BYTE_ZERO;
        end else if (regRead) begin
            unique case (regAddr)
                ADDR_RES_HIGH: rdData_q <= resHigh_q;                            // [RULE5]
                ADDR_RES_LOW:  rdData_q <= resLow_q;                             // [RULE5]
                ADDR_CONTROL:  rdData_q <= {2'h0, channel_q, justify_q};
                ADDR_STATUS:   rdData_q <= {6'h00, startPend_q, acqReady};
            endcase
        end else begin
            rdData_q <= BYTE_ZERO;
        end
    end

    assign regRdData     = rdData_q;
    assign channelSelect = channel_q;
    assign convStart     = convStart_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence convLeft;
        convDone && justify_q == JUSTIFY_LEFT;
    endsequence

    sequence convRight;
        convDone && justify_q == JUSTIFY_RIGHT;
    endsequence

    sequence startArmed;
        startPend_q && acqReady && !chanChange;
    endsequence

    // ---------------------------------------------------------------
    // cycles since the last channel change, used by the pacing check
    // ---------------------------------------------------------------
    // saturates one past the acquisition count so it never wraps
    logic [ACQ_CNT_W-1:0] sinceChange_q;

    always_ff @(posedge clock) begin
        if (sys_rst || chanChange) begin
            sinceChange_q <= '0;
        end else if (sinceChange_q != ACQ_CNT_W'(ACQ_CYCLES + 1)) begin
            sinceChange_q <= sinceChange_q + 1'b1;
        end
    end

    a_left_high_byte: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
        convLeft |=> resHigh_q == $past(convData[9:2]))
        else $error("left justified high byte wrong");

    a_left_low_byte: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
        convLeft |=> resLow_q == {$past(convData[1:0]), 6'h00})
        else $error("left justified low byte wrong");

    a_right_high_byte: assert property (@(posedge clock) disable iff (sys_rst) // [RULE3]
        convRight |=> resHigh_q == {6'h00, $past(convData[9:8])})
        else $error("right justified high byte wrong");

    a_right_low_byte: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
        convRight |=> resLow_q == $past(convData[7:0]))
        else $error("right justified low byte wrong");

    a_result_write_read: assert property (@(posedge clock) // [RULE5]
        regWrite && regAddr == ADDR_RES_HIGH && !convDone ##1 regRead && regAddr == ADDR_RES_HIGH && !convDone
        |=> regRdData == $past(regWrData, 2))
        else $error("result high byte not written by software");

    a_reset_keeps_result: assert property (@(posedge clock) // [RULE5]
        sys_rst && !convDone && !regWrite |=> $stable(resHigh_q) && $stable(resLow_q))
        else $error("result bytes disturbed by reset");

    a_both_bytes_load: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
        convDone |=> {resHigh_q, resLow_q} == $past({fmtBus.highByte, fmtBus.lowByte}))
        else $error("result bytes not loaded together");

    a_acq_before_start: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        chanChange |=> !convStart [*8])
        else $error("conversion started inside acquisition time");

    a_start_after_acq: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        startArmed |=> convStart && (!startPend_q || $past(ctlWrite && regWrData[CTL_START_BIT])))
        else $error("pending start not issued once acquired");

    a_start_paced: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        convStart |-> sinceChange_q > ACQ_CYCLES)
        else $error("conversion started before acquisition time elapsed");

    a_start_needs_pend: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        convStart |-> $past(startPend_q))
        else $error("conversion started without a request");

    a_start_one_pulse: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        convStart |=> !convStart || $past(ctlWrite && regWrData[CTL_START_BIT], 2))
        else $error("start pulse longer than one cycle");

    a_read_idle_zero: assert property (@(posedge clock) disable iff (sys_rst) // [RULE5]
        !regRead |=> regRdData == BYTE_ZERO)
        else $error("read data outside its cycle");

    a_status_read: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        regRead && regAddr == ADDR_STATUS
        |=> regRdData[STS_PEND_BIT] == $past(startPend_q) && regRdData[STS_ACQ_BIT] == $past(acqReady))
        else $error("status read wrong");

    a_reset_defaults: assert property (@(posedge clock) // [RULE5]
        sys_rst |=> channelSelect == CHAN_RESET && !convStart && regRdData == BYTE_ZERO && justify_q == JUSTIFY_LEFT)
        else $error("outputs not at reset values");

endmodule

// ### result_format_if.sv
// signals between the register block and the result formatter
`timescale 1ns/1ps
interface result_format_if;
    import adc_result_pkg::*;

    logic [RESULT_W-1:0] conversionResult;
    justify_t            resultJustifySelect;
    logic [DATA_W-1:0]   highByte;
    logic [DATA_W-1:0]   lowByte;

    modport source (output conversionResult, output resultJustifySelect, input highByte, input lowByte);
    modport formatter (input conversionResult, input resultJustifySelect, output highByte, output lowByte);
endinterface

// ### result_formatter.sv
// splits a 10-bit conversion result into two justified result bytes
`timescale 1ns/1ps
module result_formatter
    import adc_result_pkg::*;
(
    // formatting channel
    result_format_if.formatter fmt
);

    always_comb begin
        unique case (fmt.resultJustifySelect)
            JUSTIFY_LEFT: begin
                fmt.highByte = fmt.conversionResult[9:2];                         // [RULE1]
                fmt.lowByte  = {fmt.conversionResult[1:0], BYTE_ZERO[5:0]};       // [RULE2]
            end
            JUSTIFY_RIGHT: begin
                fmt.highByte = {BYTE_ZERO[5:0], fmt.conversionResult[9:8]};       // [RULE3]
                fmt.lowByte  = fmt.conversionResult[7:0];                         // [RULE4]
            end
        endcase
    end

endmodule

// ### tb.sv
// self-checking testbench for the conversion result register block
`timescale 1ns/1ps
module tb;
    import adc_result_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic                clock;
    logic                sysRst;
    logic [ADDR_W-1:0]   regAddr;
    logic [DATA_W-1:0]   regWrData;
    logic                regWrite;
    logic                regRead;
    logic [DATA_W-1:0]   regRdData;
    logic                convDone;
    logic [RESULT_W-1:0] convData;
    logic [CHAN_W-1:0]   channelSelect;
    logic                convStart;
    int                  errTotal;
    int                  checks;

    adc_result_regs DUT (
        .clock        (clock),
        .sys_rst      (sysRst),
        .regAddr      (regAddr),
        .regWrData    (regWrData),
        .regWrite     (regWrite),
        .regRead      (regRead),
        .regRdData    (regRdData),
        .convDone     (convDone),
        .convData     (convData),
        .channelSelect(channelSelect),
        .convStart    (convStart)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic doReset();
        sysRst <= 1'b1;
        repeat (6) @(posedge clock);
        sysRst <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic conv(input logic [9:0] d);
        @(posedge clock);
        convDone <= 1'b1;
        convData <= d;
        @(posedge clock);
        convDone <= 1'b0;
    endtask

    task automatic waitStart(input int limit, output int n);
        n = 0;
        #1;
        while (convStart !== 1'b1 && n < limit) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    task automatic readBoth(input logic [7:0] eh, input logic [7:0] el, input string what);
        logic [7:0] h;
        logic [7:0] l;
        rd(ADDR_RES_HIGH, h);
        rd(ADDR_RES_LOW, l);
        check(h, eh, what);
        check(l, el, what);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic testAcquisition();
        int n;
        wr(ADDR_CONTROL, 8'h40);
        waitStart(ACQ_CYCLES + 16, n);
        check(8'(n >= ACQ_CYCLES - 2 && n <= ACQ_CYCLES + 2), 8'h01, "start after acquisition");
        @(posedge clock);
        #1 check(8'(convStart), 8'h00, "start one cycle");
        wr(ADDR_CONTROL, 8'h40);
        waitStart(4, n);
        check(8'(convStart), 8'h01, "start same channel");
        wr(ADDR_CONTROL, 8'h42);
        waitStart(ACQ_CYCLES + 16, n);
        check(8'(n >= ACQ_CYCLES - 2 && n <= ACQ_CYCLES + 2), 8'h01, "start after channel change");
        check(8'(channelSelect), 8'h01, "channel");
    endtask

    task automatic testReadBack();
        logic [7:0] v;
        int         n;
        wr(ADDR_CONTROL, 8'h45);
        rd(ADDR_STATUS, v);
        check(v, 8'h02, "status pending in acquisition");
        @(posedge clock);
        #1 check(regRdData, BYTE_ZERO, "read data after its cycle");
        rd(ADDR_CONTROL, v);
        check(v, 8'h05, "control read back");
        waitStart(ACQ_CYCLES + 16, n);
        check(8'(convStart), 8'h01, "start after status read");
        rd(ADDR_STATUS, v);
        check(v, 8'h01, "status acquired and idle");
    endtask

    task automatic testLeft();
        logic [9:0] d[3] = '{10'h3ff, 10'h000, 10'h2d6};
        wr(ADDR_CONTROL, 8'h02);
        foreach (d[i]) begin
            conv(d[i]);
            readBoth(d[i][9:2], {d[i][1:0], 6'h00}, "left");
        end
    endtask

    task automatic testRight();
        logic [9:0] d[3] = '{10'h3ff, 10'h000, 10'h2d6};
        wr(ADDR_CONTROL, 8'h03);
        foreach (d[i]) begin
            conv(d[i]);
            readBoth({6'h00, d[i][9:8]}, d[i][7:0], "right");
        end
    endtask

    task automatic testKeep();
        @(posedge clock);
        regAddr   <= ADDR_RES_HIGH;
        regWrData <= 8'h96;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
        regRead   <= 1'b1;
        @(posedge clock);
        regRead   <= 1'b0;
        #1 check(regRdData, 8'h96, "write then read back to back");
        wr(ADDR_RES_HIGH, 8'ha5);
        wr(ADDR_RES_LOW, 8'h3c);
        readBoth(8'ha5, 8'h3c, "write read");
        @(posedge clock);
        doReset();
        readBoth(8'ha5, 8'h3c, "kept over reset");
    endtask

    task automatic testConvWins();
        @(posedge clock);
        regAddr   <= ADDR_RES_HIGH;
        regWrData <= 8'hff;
        regWrite  <= 1'b1;
        convDone  <= 1'b1;
        convData  <= 10'h155;
        @(posedge clock);
        regWrite  <= 1'b0;
        convDone  <= 1'b0;
        readBoth(8'h55, 8'h40, "conversion over write");
    endtask

    // ---------------------------------------------------------------
    // verdict and run control
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        if (errTotal == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100us;
        errTotal++;
        report_and_stop();
    end

    initial begin
        errTotal = 0;
        checks = 0;
        sysRst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        convDone = 1'b0;
        convData = '0;
        doReset();
        testAcquisition();
        testReadBack();
        testLeft();
        testRight();
        testKeep();
        testConvWins();
        report_and_stop();
    end
endmodule
